/* hdl/ciw_offset_bank.sv */
// card i/o window offset bank with axi4-lite register access
// assumes: one clock aclk, synchronous active-low aresetn,
// io request from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "ciw_map.svh"

// Behaviour
// - an i/o access inside a window gets the card address host address plus that window's 16-bit offset.
// - index 36h is window 0 low offset byte and 38h window 1 low offset byte, bits 7-1 holding offset 7-1.
// - index 37h is window 0 offset bits 15-8 and 39h window 1 offset bits 15-8, all read/write.
// - each of the two i/o windows has its own independent, identical offset register pair.
// - an access goes to a window only when start address <= address <= end address.
module ciw_offset_bank (
   // clock, reset, enable
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic                   ce,
   // axi4-lite write address
   input  wire logic [`CIW_AXI_AW-1:0] s_axi_awaddr,
   input  wire logic [2:0]             s_axi_awprot,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   // axi4-lite write response
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   // axi4-lite read address
   input  wire logic [`CIW_AXI_AW-1:0] s_axi_araddr,
   input  wire logic [2:0]             s_axi_arprot,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   // axi4-lite read data
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   // host i/o request
   input  wire logic                   io_req,
   input  wire logic [15:0]            io_addr,
   // translated card i/o access
   output logic                        xlat_valid,
   output logic [`CIW_NWIN-1:0]        xlat_hit,
   output logic                        xlat_win,
   output logic [15:0]                 xlat_addr
);

   // ************************************************************
   // state
   // ************************************************************
   localparam ciw_pkg::ciw_state_t ST_RST = '{default: '0};

   ciw_pkg::ciw_state_t st_reg;
   ciw_pkg::ciw_state_t st_next;

   logic [`CIW_NWIN-1:0]       win_hit;
   logic [`CIW_NWIN-1:0][15:0] win_card;
   logic [`CIW_NWIN-1:0][15:0] win_off;
   logic                       do_write;
   logic [`CIW_IDX_W-1:0]      aw_idx;
   logic [`CIW_IDX_W-1:0]      ar_idx;
   logic                       prot_unused;

   assign prot_unused = ^{s_axi_awprot, s_axi_arprot};
   assign aw_idx      = st_reg.awaddr[`CIW_AXI_AW-1:2];
   assign ar_idx      = s_axi_araddr[`CIW_AXI_AW-1:2];
   // response held back until both halves are in
   assign do_write    = st_reg.aw_full && st_reg.w_full && !st_reg.bvalid;

   // ************************************************************
   // windows
   // ************************************************************
   for (genvar i = 0; i < `CIW_NWIN; i++) begin : g_win
      // bit 0 of the low byte is used as stored, software keeps it zero
      assign win_off[i] = {st_reg.off_hi[i], st_reg.off_lo[i]};

      ciw_io_window u_win (
         .win_start  (st_reg.win_start[i]),
         .win_end    (st_reg.win_end[i]),
         .win_offset (win_off[i]),
         .host_addr  (io_addr),
         .hit        (win_hit[i]),
         .card_addr  (win_card[i])
      );
   end

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      st_next            = st_reg;
      st_next.xlat_valid = 1'b0;

      // write channels, taken in either order
      if (s_axi_awvalid && st_reg.awready) begin
         st_next.aw_full = 1'b1;
         st_next.awaddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_reg.wready) begin
         st_next.w_full = 1'b1;
         st_next.wdata  = s_axi_wdata;
         st_next.wstrb  = s_axi_wstrb;
      end
      if (st_reg.bvalid && s_axi_bready) begin
         st_next.bvalid = 1'b0;
      end

      if (do_write) begin
         st_next.aw_full = 1'b0;
         st_next.w_full  = 1'b0;
         st_next.bvalid  = 1'b1;
         st_next.bresp   = `CIW_RESP_OKAY;
         unique case (aw_idx)
            `CIW_IDX_W0_OFF_LO: begin
               if (st_reg.wstrb[0]) st_next.off_lo[0] = st_reg.wdata[7:0];
            end
            `CIW_IDX_W1_OFF_LO: begin
               if (st_reg.wstrb[0]) st_next.off_lo[1] = st_reg.wdata[7:0];
            end
            `CIW_IDX_W0_OFF_HI: begin
               if (st_reg.wstrb[0]) st_next.off_hi[0] = st_reg.wdata[7:0];
            end
            `CIW_IDX_W1_OFF_HI: begin
               if (st_reg.wstrb[0]) st_next.off_hi[1] = st_reg.wdata[7:0];
            end
            `CIW_IDX_W0_START: begin
               if (st_reg.wstrb[0]) st_next.win_start[0][7:0]  = st_reg.wdata[7:0];
               if (st_reg.wstrb[1]) st_next.win_start[0][15:8] = st_reg.wdata[15:8];
            end
            `CIW_IDX_W0_END: begin
               if (st_reg.wstrb[0]) st_next.win_end[0][7:0]  = st_reg.wdata[7:0];
               if (st_reg.wstrb[1]) st_next.win_end[0][15:8] = st_reg.wdata[15:8];
            end
            `CIW_IDX_W1_START: begin
               if (st_reg.wstrb[0]) st_next.win_start[1][7:0]  = st_reg.wdata[7:0];
               if (st_reg.wstrb[1]) st_next.win_start[1][15:8] = st_reg.wdata[15:8];
            end
            `CIW_IDX_W1_END: begin
               if (st_reg.wstrb[0]) st_next.win_end[1][7:0]  = st_reg.wdata[7:0];
               if (st_reg.wstrb[1]) st_next.win_end[1][15:8] = st_reg.wdata[15:8];
            end
            // status is read-only: write accepted, nothing changes
            `CIW_IDX_STATUS: begin
               st_next.bresp = `CIW_RESP_OKAY;
            end
            default: begin
               st_next.bresp = `CIW_RESP_SLVERR;
            end
         endcase
      end
      // one write in flight at a time
      st_next.awready = !st_next.aw_full && !st_next.bvalid;
      st_next.wready  = !st_next.w_full && !st_next.bvalid;

      // read channel
      if (st_reg.rvalid && s_axi_rready) begin
         st_next.rvalid = 1'b0;
      end
      if (s_axi_arvalid && st_reg.arready) begin
         st_next.rvalid = 1'b1;
         st_next.rdata  = 32'h0000_0000;
         st_next.rresp  = `CIW_RESP_OKAY;
         unique case (ar_idx)
            `CIW_IDX_W0_OFF_LO: st_next.rdata[7:0]  = st_reg.off_lo[0];
            `CIW_IDX_W1_OFF_LO: st_next.rdata[7:0]  = st_reg.off_lo[1];
            `CIW_IDX_W0_OFF_HI: st_next.rdata[7:0]  = st_reg.off_hi[0];
            `CIW_IDX_W1_OFF_HI: st_next.rdata[7:0]  = st_reg.off_hi[1];
            `CIW_IDX_W0_START:  st_next.rdata[15:0] = st_reg.win_start[0];
            `CIW_IDX_W0_END:    st_next.rdata[15:0] = st_reg.win_end[0];
            `CIW_IDX_W1_START:  st_next.rdata[15:0] = st_reg.win_start[1];
            `CIW_IDX_W1_END:    st_next.rdata[15:0] = st_reg.win_end[1];
            `CIW_IDX_STATUS: begin
               st_next.rdata[`CIW_ST_ADDR_LSB +: 16]       = st_reg.xlat_addr;
               st_next.rdata[`CIW_ST_HIT_LSB +: `CIW_NWIN] = st_reg.xlat_hit;
               st_next.rdata[`CIW_ST_WIN_BIT]              = st_reg.xlat_win;
            end
            default:            st_next.rresp = `CIW_RESP_SLVERR;
         endcase
      end
      st_next.arready = !st_next.rvalid;

      // translation; overlapping windows are a setup error, window 0 wins
      if (io_req) begin
         st_next.xlat_valid = 1'b1;
         st_next.xlat_hit   = win_hit;
         st_next.xlat_win   = !win_hit[0] && win_hit[1];
         if (win_hit[0]) begin
            st_next.xlat_addr = win_card[0];
         end else if (win_hit[1]) begin
            st_next.xlat_addr = win_card[1];
         end else begin
            st_next.xlat_addr = io_addr;
         end
      end
   end

   // ************************************************************
   // register
   // ************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg <= ST_RST;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign s_axi_awready = st_reg.awready;
   assign s_axi_wready  = st_reg.wready;
   assign s_axi_bvalid  = st_reg.bvalid;
   assign s_axi_bresp   = st_reg.bresp;
   assign s_axi_arready = st_reg.arready;
   assign s_axi_rvalid  = st_reg.rvalid;
   assign s_axi_rdata   = st_reg.rdata;
   assign s_axi_rresp   = st_reg.rresp;
   assign xlat_valid    = st_reg.xlat_valid;
   assign xlat_hit      = st_reg.xlat_hit;
   assign xlat_win      = st_reg.xlat_win;
   assign xlat_addr     = st_reg.xlat_addr;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge aclk); endclocking

   xlat_add_a: assert property (
      disable iff (!aresetn)
      (ce && io_req && win_hit[0]) |=> (xlat_addr == 16'($past(io_addr) + $past(win_off[0]))))
      else $error("window 0 card address is not host address plus offset");

   lo_write_a: assert property (
      disable iff (!aresetn)
      (ce && do_write && aw_idx == `CIW_IDX_W1_OFF_LO && st_reg.wstrb[0])
      |=> (st_reg.off_lo[1] == $past(st_reg.wdata[7:0])))
      else $error("low offset byte of window 1 not written");

   hi_read_a: assert property (
      disable iff (!aresetn)
      (ce && s_axi_arvalid && s_axi_arready && ar_idx == `CIW_IDX_W0_OFF_HI && !do_write)
      |=> (s_axi_rvalid && s_axi_rdata == {24'h00_0000, $past(st_reg.off_hi[0])}))
      else $error("high offset byte of window 0 read back wrong");

   win_indep_a: assert property (
      disable iff (!aresetn)
      (do_write && (aw_idx == `CIW_IDX_W0_OFF_LO || aw_idx == `CIW_IDX_W0_OFF_HI))
      |=> $stable(win_off[1]))
      else $error("window 0 write disturbed window 1 offset");

   range_miss_a: assert property (
      disable iff (!aresetn)
      (ce && io_req && (io_addr < st_reg.win_start[1] || io_addr > st_reg.win_end[1]))
      |=> (xlat_valid && !xlat_hit[1]))
      else $error("window 1 hit outside its range");

   wrap_add_a: assert property (
      disable iff (!aresetn)
      (ce && io_req && win_hit[0] && (17'(io_addr) + 17'(win_off[0])) > 17'h0_FFFF)
      |=> (xlat_addr < $past(io_addr)))
      else $error("offset addition did not wrap");

   reset_zero_a: assert property (
      !aresetn |=> (win_off[0] == 16'h0000 && win_off[1] == 16'h0000))
      else $error("offsets not zero after reset");

   write_resp_a: assert property (
      disable iff (!aresetn)
      (ce && do_write) |=> s_axi_bvalid ##0 !s_axi_awready)
      else $error("write response missing");

   hi_write_a: assert property (
      disable iff (!aresetn)
      (ce && do_write && aw_idx == `CIW_IDX_W1_OFF_HI && st_reg.wstrb[0])
      |=> (st_reg.off_hi[1] == $past(st_reg.wdata[7:0])))
      else $error("high offset byte of window 1 not written");

   lane_keep_a: assert property (
      disable iff (!aresetn)
      (ce && do_write && aw_idx == `CIW_IDX_W0_OFF_LO && !st_reg.wstrb[0])
      |=> $stable(st_reg.off_lo[0]))
      else $error("low offset byte of window 0 changed with its lane off");

   range_hit_a: assert property (
      disable iff (!aresetn)
      (ce && io_req && io_addr >= st_reg.win_start[0] && io_addr <= st_reg.win_end[0])
      |=> (xlat_valid && xlat_hit[0] && !xlat_win))
      else $error("window 0 missed inside its range");

   xlat_pulse_a: assert property (
      disable iff (!aresetn)
      (ce && !io_req) |=> !xlat_valid)
      else $error("translation pulse without a request");

   // a frozen request must leave no trace at all
   ce_freeze_a: assert property (
      disable iff (!aresetn)
      !ce |=> $stable(st_reg))
      else $error("state moved while clock enable was low");

   cv_lo_write: cover property (disable iff (!aresetn) do_write && aw_idx == `CIW_IDX_W0_OFF_LO);
   cv_win1_hit: cover property (disable iff (!aresetn) xlat_valid && xlat_win);
   cv_bad_read: cover property (disable iff (!aresetn) s_axi_rvalid && s_axi_rresp == `CIW_RESP_SLVERR);
   cv_frozen_req: cover property (disable iff (!aresetn) !ce && io_req);

endmodule : ciw_offset_bank

`default_nettype wire

/* hdl/ciw_map.svh */
// register map and constants of the card i/o window offset bank
// assumes: included by the package, the offset bank and the bench by bare name
`ifndef CIW_MAP_SVH
`define CIW_MAP_SVH

// bus geometry
`define CIW_AXI_AW         12
`define CIW_IDX_W          10

// printed register indexes; byte address is four times the index
`define CIW_IDX_W0_OFF_LO  10'h036
`define CIW_IDX_W0_OFF_HI  10'h037
`define CIW_IDX_W1_OFF_LO  10'h038
`define CIW_IDX_W1_OFF_HI  10'h039

// window compare and status registers
`define CIW_IDX_W0_START   10'h040
`define CIW_IDX_W0_END     10'h041
`define CIW_IDX_W1_START   10'h042
`define CIW_IDX_W1_END     10'h043
`define CIW_IDX_STATUS     10'h044

// field positions of the status word
`define CIW_ST_ADDR_LSB    0
`define CIW_ST_HIT_LSB     16
`define CIW_ST_WIN_BIT     18

// reset values
`define CIW_OFF_RST        8'h00
`define CIW_START_RST      16'h0000
`define CIW_END_RST        16'h0000

// bus responses
`define CIW_RESP_OKAY      2'h0
`define CIW_RESP_SLVERR    2'h2

// window count
`define CIW_NWIN           2

`endif

/* hdl/ciw_pkg.sv */
// types of the card i/o window offset bank
// assumes: ciw_map.svh on the include path
`include "ciw_map.svh"

package ciw_pkg;

   typedef logic [`CIW_NWIN-1:0][7:0]  ciw_byte_arr_t;
   typedef logic [`CIW_NWIN-1:0][15:0] ciw_word_arr_t;

   typedef struct packed {
      logic                    aw_full;
      logic [`CIW_AXI_AW-1:0]  awaddr;
      logic                    w_full;
      logic [31:0]             wdata;
      logic [3:0]              wstrb;
      logic                    awready;
      logic                    wready;
      logic                    bvalid;
      logic [1:0]              bresp;
      logic                    arready;
      logic                    rvalid;
      logic [31:0]             rdata;
      logic [1:0]              rresp;
      ciw_byte_arr_t           off_lo;
      ciw_byte_arr_t           off_hi;
      ciw_word_arr_t           win_start;
      ciw_word_arr_t           win_end;
      logic                    xlat_valid;
      logic [`CIW_NWIN-1:0]    xlat_hit;
      logic                    xlat_win;
      logic [15:0]             xlat_addr;
   } ciw_state_t;

endpackage : ciw_pkg

/* hdl/ciw_io_window.sv */
// one i/o window: range compare and offset addition
// assumes: purely combinational, registered by the instantiating bank
`timescale 1ns/1ps
`default_nettype none

module ciw_io_window (
   // window settings
   input  wire logic [15:0] win_start,
   input  wire logic [15:0] win_end,
   input  wire logic [15:0] win_offset,
   // host side
   input  wire logic [15:0] host_addr,
   // result
   output logic             hit,
   output logic [15:0]      card_addr
);

   // inclusive at both ends
   assign hit       = (host_addr >= win_start) && (host_addr <= win_end);
   // carry out of bit 15 dropped on purpose
   assign card_addr = 16'(host_addr + win_offset);

endmodule : ciw_io_window

`default_nettype wire

/* verification/ciw_offset_bank_bench.sv */
// self-checking bench of the card i/o window offset bank
// assumes: ciw_map.svh on the include path, ciw_offset_bank compiled before
`timescale 1ns/1ps
`default_nettype none
`include "ciw_map.svh"

module ciw_offset_bank_bench;
   // ************************************************************
   // stimulus and observed signals
   // ************************************************************
   logic                    aclk    = 1'b0;
   logic                    aresetn = 1'b0;
   logic                    ce      = 1'b1;
   logic [`CIW_AXI_AW-1:0]  awaddr  = '0;
   logic [`CIW_AXI_AW-1:0]  araddr  = '0;
   logic [31:0]             wdata   = 32'h0000_0000;
   logic                    awvalid = 1'b0;
   logic                    wvalid  = 1'b0;
   logic                    bready  = 1'b0;
   logic                    arvalid = 1'b0;
   logic                    rready  = 1'b0;
   logic                    io_req  = 1'b0;
   logic [15:0]             io_addr = 16'h0000;
   logic [3:0]              wstrb   = 4'hf;
   logic [18:0]             last_e  = '0;
   logic                    awready, wready, bvalid, arready, rvalid, xlat_valid, xlat_win;
   logic [1:0]              bresp, rresp, xlat_hit;
   logic [31:0]             rdata;
   logic [15:0]             xlat_addr;
   logic [31:0]             seed = 32'h0000_0053;
   logic [7:0]              lo_m [2];
   logic [7:0]              hi_m [2];
   logic [15:0]             st_m [2];
   logic [15:0]             en_m [2];
   logic [15:0]             edges [8] = '{16'h00ff, 16'h0100, 16'h01ff, 16'h0200,
                                          16'h017f, 16'h0180, 16'h0300, 16'h0301};
   int                      err_total = 0;
   int                      n_checks  = 0;

   always #10 aclk = ~aclk;

   ciw_offset_bank u_ciw_offset_bank (
      .aclk(aclk), .aresetn(aresetn), .ce(ce),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .io_req(io_req), .io_addr(io_addr),
      .xlat_valid(xlat_valid), .xlat_hit(xlat_hit), .xlat_win(xlat_win), .xlat_addr(xlat_addr)
   );

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   // {win, hit[1:0], card address}; window 0 wins an overlap
   function automatic logic [18:0] exp_x(input logic [15:0] a);
      logic        h0, h1;
      logic [15:0] o;
      h0 = (a >= st_m[0]) && (a <= en_m[0]);
      h1 = (a >= st_m[1]) && (a <= en_m[1]);
      o  = h0 ? a + {hi_m[0], lo_m[0]} : (h1 ? a + {hi_m[1], lo_m[1]} : a);
      return {~h0 & h1, h1, h0, o};
   endfunction : exp_x

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
      end
   endtask : chk_word

   task automatic chk_x(input logic [19:0] got, input logic [19:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: translation %h, wanted %h", $time, got, exp);
      end
   endtask : chk_x

   task automatic timed_out();
      err_total++;
      $display("unexpected at %0t: no bus answer", $time);
      report_and_stop();
   endtask : timed_out

   // ************************************************************
   // bus cycles
   // ************************************************************
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 50);
      if (n >= 50) timed_out();
      bready <= 1'b0;
      chk_word({30'h0, bresp}, {30'h0, er});
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 50);
      if (n >= 50) timed_out();
      rready <= 1'b0;
      chk_word(rdata, ed);
      chk_word({30'h0, rresp}, {30'h0, er});
   endtask : rd

   task automatic do_reset();
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      last_e = '0;
      for (int w = 0; w < 2; w++) begin
         lo_m[w] = 8'h00; hi_m[w] = 8'h00; st_m[w] = 16'h0000; en_m[w] = 16'h0000;
      end
   endtask : do_reset

   // offsets of both windows read back; upper bits must read zero
   task automatic check_offs();
      for (int w = 0; w < 2; w++) begin
         rd(12'h0d8 + 12'(8 * w), {24'h0, lo_m[w]}, `CIW_RESP_OKAY);
         rd(12'h0dc + 12'(8 * w), {24'h0, hi_m[w]}, `CIW_RESP_OKAY);
      end
   endtask : check_offs

   task automatic setup(input int w, input logic [7:0] l, input logic [7:0] h,
                        input logic [15:0] s, input logic [15:0] e);
      lo_m[w] = l & 8'hfe; hi_m[w] = h; st_m[w] = s; en_m[w] = e;
      wr(12'h0d8 + 12'(8 * w), {xs() & 32'hffff_ff00} | {24'h0, lo_m[w]}, `CIW_RESP_OKAY);
      wr(12'h0dc + 12'(8 * w), {xs() & 32'hffff_ff00} | {24'h0, h}, `CIW_RESP_OKAY);
      wr(12'h100 + 12'(8 * w), {16'h0, s}, `CIW_RESP_OKAY);
      wr(12'h104 + 12'(8 * w), {16'h0, e}, `CIW_RESP_OKAY);
      check_offs();
   endtask : setup

   task automatic xl(input logic [15:0] a);
      logic [18:0] e;
      e = exp_x(a);
      last_e = e;
      @(posedge aclk);
      io_req <= 1'b1; io_addr <= a;
      @(posedge aclk);
      io_req <= 1'b0; io_addr <= ~a;
      @(negedge aclk);
      chk_x({xlat_valid, xlat_win, xlat_hit, xlat_addr}, {1'b1, e});
      @(negedge aclk);
      chk_x({xlat_valid, xlat_win, xlat_hit, xlat_addr}, {1'b0, e});
      rd(12'h110, {13'h0, e}, `CIW_RESP_OKAY);
   endtask : xl

   // request offered only while clock enable is low: outputs keep the last result
   task automatic frozen(input logic [15:0] a);
      @(posedge aclk);
      ce <= 1'b0;
      io_req <= 1'b1;
      io_addr <= a;
      repeat (2) @(posedge aclk);
      ce <= 1'b1;
      io_req <= 1'b0;
      @(negedge aclk);
      chk_x({xlat_valid, xlat_win, xlat_hit, xlat_addr}, {1'b0, last_e});
   endtask : frozen

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      logic [15:0] s;
      logic [31:0] t;
      do_reset();
      check_offs();
      rd(12'h000, 32'h0000_0000, `CIW_RESP_SLVERR);
      wr(12'h0e8, 32'h0000_00aa, `CIW_RESP_SLVERR);
      // status is read-only: the write is answered but changes nothing
      wr(12'h110, 32'hffff_ffff, `CIW_RESP_OKAY);
      rd(12'h110, 32'h0000_0000, `CIW_RESP_OKAY);
      // carry out of bit 15 is dropped; windows overlap at 0180h-01ffh
      setup(0, 8'hfe, 8'hff, 16'h0100, 16'h01ff);
      setup(1, 8'h10, 8'h20, 16'h0180, 16'h0300);
      // lane 0 off: the low offset byte keeps its value
      wstrb <= 4'he;
      wr(12'h0d8, 32'h0000_0022, `CIW_RESP_OKAY);
      wstrb <= 4'hf;
      check_offs();
      foreach (edges[i]) xl(edges[i]);
      frozen(16'h0150);
      for (int r = 0; r < 6; r++) begin
         t = xs();
         s = t[15:0];
         setup(int'(t[16]), t[31:24], t[23:16], s, s + 16'(xs() & 32'h0000_0fff));
         for (int k = 0; k < 6; k++) xl(s + 16'(xs() & 32'h0000_1fff) - 16'h0400);
      end
      do_reset();
      check_offs();
      frozen(16'h0001);
      xl(16'h0000);
      xl(16'h0001);
      report_and_stop();
   end
endmodule : ciw_offset_bank_bench

`default_nettype wire
